/* File: rtl/oolim_defs.svh */
`ifndef OOLIM_DEFS_SVH
`define OOLIM_DEFS_SVH

// Clock and slope-time units
`define OOLIM_CLK_HZ 25000000
`define OOLIM_SLOPE_UNIT_MS 100
`define OOLIM_CYC_PER_UNIT (`OOLIM_CLK_HZ / 1000 * `OOLIM_SLOPE_UNIT_MS)

// Slope time range, in 0.1 s units
`define OOLIM_SLOPE_MIN 16'h0001
`define OOLIM_SLOPE_MAX 16'h7530

// Thresholds as hundredths of rated current
`define OOLIM_THR_MIN 8'h14
`define OOLIM_THR_MAX_ND 8'hC8
`define OOLIM_THR_MAX_LD 8'h96
`define OOLIM_OC_LEVEL 8'hB4
`define OOLIM_PCT_SCALE 8'h64

// Overcurrent suppression codes
`define OOLIM_OCS_OFF 2'h0
`define OOLIM_OCS_ON 2'h1
`define OOLIM_OCS_VRED 2'h2

`endif

/* File: rtl/oolim_pkg.sv */
`default_nettype none
package oolim_pkg;
  typedef enum logic [1:0] {
    OOLIM_LIM_OFF,
    OOLIM_LIM_ACC_STEADY,
    OOLIM_LIM_STEADY,
    OOLIM_LIM_REGEN
  } oolim_mode_t;

  typedef enum logic [2:0] {
    OOLIM_ST_STEADY,
    OOLIM_ST_ACCEL,
    OOLIM_ST_DECEL,
    OOLIM_ST_LIM_DOWN,
    OOLIM_ST_REGEN_UP
  } oolim_state_t;
endpackage
`default_nettype wire

/* File: rtl/oolim_cur_if.sv */
`default_nettype none
interface oolim_cur_if;
  logic [15:0] current;
  logic [15:0] rated;
  logic [7:0] thr;
  logic over_lim;
  logic over_oc;
  modport ctl (output current, output rated, output thr,
               input over_lim, input over_oc);
  modport cmp (input current, input rated, input thr,
               output over_lim, output over_oc);
endinterface
`default_nettype wire

/* File: rtl/oolim_cmp.sv */
`default_nettype none
`include "oolim_defs.svh"
module oolim_cmp (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  oolim_cur_if.cmp cur
);
  logic [31:0] meas_scaled;
  logic [31:0] lim_level;
  logic [31:0] oc_level;

  // Current compared as current*100 against multiple*rated
  assign meas_scaled = cur.current * 32'(`OOLIM_PCT_SCALE);
  assign lim_level = 32'(cur.thr) * 32'(cur.rated);
  assign oc_level = 32'(`OOLIM_OC_LEVEL) * 32'(cur.rated);
  assign cur.over_lim = meas_scaled >= lim_level;
  assign cur.over_oc = meas_scaled > oc_level;

  property p_oc_level;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (32'(cur.current) * 32'h0000_0064 > 32'(cur.rated) * 32'h0000_00B4)
      |-> cur.over_oc;
  endproperty
  a_oc_level: assert property (p_oc_level)
    else $error("current above 180 percent not flagged");
endmodule
`default_nettype wire

/* File: rtl/oolim_rate.sv */
`default_nettype none
`include "oolim_defs.svh"
module oolim_rate #(
  parameter int FW = 16,
  parameter longint CYC_PER_UNIT = `OOLIM_CYC_PER_UNIT
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [15:0] i_time,
  input wire logic [FW-1:0] i_fmax,
  output logic o_step
);
  logic [47:0] acc_reg;
  logic [47:0] acc_sum;
  logic [47:0] span;
  logic [15:0] time_eff;

  // Time clamped to the programmable range
  assign time_eff = (i_time < `OOLIM_SLOPE_MIN) ? `OOLIM_SLOPE_MIN :
                    (i_time > `OOLIM_SLOPE_MAX) ? `OOLIM_SLOPE_MAX :
                    i_time;
  // Full-scale travel fmax..0 takes time_eff units: one LSB per span/fmax
  assign span = 48'(time_eff) * 48'(CYC_PER_UNIT);
  assign acc_sum = acc_reg + 48'(i_fmax);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg <= 48'h0000_0000_0000;
      o_step <= 1'b0;
    end else if (!i_enable) begin
      acc_reg <= 48'h0000_0000_0000;
      o_step <= 1'b0;
    end else if (acc_sum >= span) begin
      acc_reg <= acc_sum - span;
      o_step <= 1'b1;
    end else begin
      acc_reg <= acc_sum;
      o_step <= 1'b0;
    end
  end

  property p_idle_no_step;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !i_enable |=> !o_step;
  endproperty
  a_idle_no_step: assert property (p_idle_no_step)
    else $error("slope step without enable");
endmodule
`default_nettype wire

/* File: rtl/oolim_top.sv */
// Behaviour
// - Overload in accel or steady lowers frequency at the slope rate.
// - Two limit sets; selector input chooses which one is active.
// - Mode 02 limits only when a load surge hits at steady speed.
// - Mode 03 acts as 01 and accelerates on regenerative load at steady.
// - Threshold 0.20 to 2.00 rated (normal duty), 0.20 to 1.50 (light).
// - Set two takes same ranges as set one, used when selector is on.
// - Limiting in acceleration stretches the time to reach the command.
// - With suppression on, current above 180% rated engages suppression.
// - Suppression code 00 off, 01 on, 02 on with voltage reduction.
// - Code 02 lowers output voltage while suppression is active.
`default_nettype none
`include "oolim_defs.svh"
module oolim_top #(
  parameter int FW = 16,
  parameter longint CYC_PER_UNIT = `OOLIM_CYC_PER_UNIT
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic [FW-1:0] i_freq_cmd,
  input wire logic [FW-1:0] i_fmax,
  input wire logic [15:0] i_accel_time,
  input wire logic [15:0] i_decel_time,
  input wire logic i_limit_set_select_input,
  input wire logic [1:0] i_overload_limit1_mode,
  input wire logic [7:0] i_overload_limit1_threshold,
  input wire logic [15:0] i_overload_limit1_slope_time,
  input wire logic [1:0] i_overload_limit2_mode,
  input wire logic [7:0] i_overload_limit2_threshold,
  input wire logic [15:0] i_overload_limit2_slope_time,
  input wire logic [1:0] i_overcurrent_suppress_mode,
  input wire logic i_light_duty_rating,
  input wire logic [15:0] i_current,
  input wire logic [15:0] i_rated_current,
  input wire logic i_regen_load,
  output logic [FW-1:0] o_freq_out,
  output logic o_steady,
  output logic o_limiting,
  output logic o_regen_accel,
  output logic o_oc_suppress,
  output logic o_volt_reduce
);
  logic rst_meta_reg;
  logic rst_n;
  oolim_pkg::oolim_state_t state_reg;
  oolim_pkg::oolim_state_t state_next;
  oolim_pkg::oolim_mode_t mode;
  logic [7:0] thr_raw;
  logic [7:0] thr_max;
  logic [15:0] slope_time;
  logic [FW-1:0] cmd_eff;
  logic [2:0] rate_en;
  logic [2:0] rate_step;
  logic [15:0] rate_time [3];
  logic ovl;
  logic oc_on;
  logic regen_on;
  logic oc_act_next;

  oolim_cur_if cur ();

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  function automatic oolim_pkg::oolim_state_t ramp_dir(
    input logic [FW-1:0] f,
    input logic [FW-1:0] c
  );
    if (f < c) begin
      ramp_dir = oolim_pkg::OOLIM_ST_ACCEL;
    end else if (f > c) begin
      ramp_dir = oolim_pkg::OOLIM_ST_DECEL;
    end else begin
      ramp_dir = oolim_pkg::OOLIM_ST_STEADY;
    end
  endfunction

  // Active parameter set follows the selector level
  assign mode = oolim_pkg::oolim_mode_t'(i_limit_set_select_input ?
                i_overload_limit2_mode : i_overload_limit1_mode);
  assign thr_raw = i_limit_set_select_input ? i_overload_limit2_threshold :
                   i_overload_limit1_threshold;
  assign slope_time = i_limit_set_select_input ?
                      i_overload_limit2_slope_time :
                      i_overload_limit1_slope_time;
  assign thr_max = i_light_duty_rating ? `OOLIM_THR_MAX_LD :
                   `OOLIM_THR_MAX_ND;
  assign cur.thr = (thr_raw < `OOLIM_THR_MIN) ? `OOLIM_THR_MIN :
                   (thr_raw > thr_max) ? thr_max : thr_raw;
  assign cur.current = i_current;
  assign cur.rated = i_rated_current;

  oolim_cmp u_cmp (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .cur(cur.cmp)
  );

  assign cmd_eff = !i_run ? '0 :
                   (i_freq_cmd > i_fmax) ? i_fmax : i_freq_cmd;

  assign ovl = cur.over_lim && (mode != oolim_pkg::OOLIM_LIM_OFF);
  assign oc_on = cur.over_oc &&
                 (i_overcurrent_suppress_mode == `OOLIM_OCS_ON ||
                  i_overcurrent_suppress_mode == `OOLIM_OCS_VRED);
  assign regen_on = i_regen_load &&
                    (mode == oolim_pkg::OOLIM_LIM_REGEN);

  // Slope generators: accel, decel, limiting slope
  assign rate_time[0] = i_accel_time;
  assign rate_time[1] = i_decel_time;
  assign rate_time[2] = slope_time;
  assign rate_en[0] = state_reg == oolim_pkg::OOLIM_ST_ACCEL;
  assign rate_en[1] = state_reg == oolim_pkg::OOLIM_ST_DECEL;
  assign rate_en[2] = state_reg == oolim_pkg::OOLIM_ST_LIM_DOWN ||
                      state_reg == oolim_pkg::OOLIM_ST_REGEN_UP;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_rate
      oolim_rate #(.FW(FW), .CYC_PER_UNIT(CYC_PER_UNIT)) u_rate (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_enable(rate_en[g]),
        .i_time(rate_time[g]),
        .i_fmax(i_fmax),
        .o_step(rate_step[g])
      );
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      oolim_pkg::OOLIM_ST_STEADY: begin
        if (ovl || oc_on) begin
          state_next = oolim_pkg::OOLIM_ST_LIM_DOWN;
        end else if (regen_on) begin
          state_next = oolim_pkg::OOLIM_ST_REGEN_UP;
        end else begin
          state_next = ramp_dir(o_freq_out, cmd_eff);
        end
      end
      oolim_pkg::OOLIM_ST_ACCEL: begin
        // Mode 02 ignores overload while accelerating
        if ((ovl && mode != oolim_pkg::OOLIM_LIM_STEADY) || oc_on) begin
          state_next = oolim_pkg::OOLIM_ST_LIM_DOWN;
        end else begin
          state_next = ramp_dir(o_freq_out, cmd_eff);
        end
      end
      oolim_pkg::OOLIM_ST_DECEL: begin
        if (oc_on) begin
          state_next = oolim_pkg::OOLIM_ST_LIM_DOWN;
        end else begin
          state_next = ramp_dir(o_freq_out, cmd_eff);
        end
      end
      oolim_pkg::OOLIM_ST_LIM_DOWN: begin
        if (!ovl && !oc_on) begin
          state_next = ramp_dir(o_freq_out, cmd_eff);
        end
      end
      oolim_pkg::OOLIM_ST_REGEN_UP: begin
        if (ovl || oc_on) begin
          state_next = oolim_pkg::OOLIM_ST_LIM_DOWN;
        end else if (!regen_on) begin
          state_next = ramp_dir(o_freq_out, cmd_eff);
        end
      end
      default: state_next = oolim_pkg::OOLIM_ST_STEADY;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= oolim_pkg::OOLIM_ST_STEADY;
    end else begin
      state_reg <= state_next;
    end
  end

  // Output frequency moves one LSB per slope step
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_freq_out <= '0;
    end else begin
      case (state_reg)
        oolim_pkg::OOLIM_ST_ACCEL: begin
          if (rate_step[0] && o_freq_out < cmd_eff) begin
            o_freq_out <= o_freq_out + 1'b1;
          end
        end
        oolim_pkg::OOLIM_ST_DECEL: begin
          if (rate_step[1] && o_freq_out > cmd_eff) begin
            o_freq_out <= o_freq_out - 1'b1;
          end
        end
        oolim_pkg::OOLIM_ST_LIM_DOWN: begin
          if (rate_step[2] && o_freq_out != '0) begin
            o_freq_out <= o_freq_out - 1'b1;
          end
        end
        oolim_pkg::OOLIM_ST_REGEN_UP: begin
          if (rate_step[2] && o_freq_out < i_fmax) begin
            o_freq_out <= o_freq_out + 1'b1;
          end
        end
        default: o_freq_out <= o_freq_out;
      endcase
    end
  end

  assign oc_act_next = oc_on &&
                       state_next == oolim_pkg::OOLIM_ST_LIM_DOWN;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_oc_suppress <= 1'b0;
      o_volt_reduce <= 1'b0;
    end else begin
      o_oc_suppress <= oc_act_next;
      o_volt_reduce <= oc_act_next &&
        i_overcurrent_suppress_mode == `OOLIM_OCS_VRED;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_steady <= 1'b0;
      o_limiting <= 1'b0;
      o_regen_accel <= 1'b0;
    end else begin
      o_steady <= state_next == oolim_pkg::OOLIM_ST_STEADY;
      o_limiting <= state_next == oolim_pkg::OOLIM_ST_LIM_DOWN;
      o_regen_accel <= state_next == oolim_pkg::OOLIM_ST_REGEN_UP;
    end
  end

  property p_lim_step;
    @(posedge i_mclk) disable iff (!rst_n)
      (state_reg == oolim_pkg::OOLIM_ST_LIM_DOWN && rate_step[2] &&
       o_freq_out != '0) |=> o_freq_out == $past(o_freq_out) - 1'b1;
  endproperty
  a_lim_step: assert property (p_lim_step)
    else $error("limit step did not lower frequency");

  property p_set_select;
    @(posedge i_mclk) disable iff (!rst_n)
      i_limit_set_select_input |-> slope_time == i_overload_limit2_slope_time
      && mode == oolim_pkg::oolim_mode_t'(i_overload_limit2_mode);
  endproperty
  a_set_select: assert property (p_set_select)
    else $error("second set not used with selector on");

  property p_mode_off;
    @(posedge i_mclk) disable iff (!rst_n)
      (mode == oolim_pkg::OOLIM_LIM_OFF && !oc_on) |=> !o_limiting;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("limiting with mode off");

  property p_steady_only;
    @(posedge i_mclk) disable iff (!rst_n)
      (mode == oolim_pkg::OOLIM_LIM_STEADY && !oc_on &&
       state_reg == oolim_pkg::OOLIM_ST_ACCEL) |=> !o_limiting;
  endproperty
  a_steady_only: assert property (p_steady_only)
    else $error("mode 02 limited during acceleration");

  property p_regen_up;
    @(posedge i_mclk) disable iff (!rst_n)
      (state_reg == oolim_pkg::OOLIM_ST_REGEN_UP && rate_step[2] &&
       o_freq_out < i_fmax) |=> o_freq_out == $past(o_freq_out) + 1'b1;
  endproperty
  a_regen_up: assert property (p_regen_up)
    else $error("regenerative acceleration missing");

  property p_thr_range;
    @(posedge i_mclk) disable iff (!rst_n)
      cur.thr >= 8'h14 && cur.thr <= (i_light_duty_rating ? 8'h96 : 8'hC8);
  endproperty
  a_thr_range: assert property (p_thr_range)
    else $error("threshold outside rating range");

  property p_stretch;
    @(posedge i_mclk) disable iff (!rst_n)
      state_reg == oolim_pkg::OOLIM_ST_LIM_DOWN |=>
        o_freq_out <= $past(o_freq_out);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("frequency rose while limiting");

  property p_vred;
    @(posedge i_mclk) disable iff (!rst_n)
      o_volt_reduce |-> o_oc_suppress && o_limiting &&
        $past(i_overcurrent_suppress_mode) == 2'h2;
  endproperty
  a_vred: assert property (p_vred)
    else $error("voltage reduced outside code 02 suppression");

  property p_release;
    @(posedge i_mclk) disable iff (!rst_n)
      (!ovl && !oc_on && state_reg == oolim_pkg::OOLIM_ST_LIM_DOWN)
      |=> !o_limiting;
  endproperty
  a_release: assert property (p_release)
    else $error("limiting held below threshold");
endmodule
`default_nettype wire

/* File: test/oolim_stage.sv */
`default_nettype none
// Power stage stand-in: measured current follows the load with one cycle lag
module oolim_stage #(
  parameter logic [15:0] RATED = 16'h03E8
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [15:0] i_load,
  input wire logic i_regen,
  output logic [15:0] o_current,
  output logic [15:0] o_rated,
  output logic o_regen
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_rated = RATED;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_current <= 16'h0000;
      o_regen <= 1'b0;
    end else begin
      o_current <= i_load;
      o_regen <= i_regen;
    end
  end
endmodule
`default_nettype wire

/* File: test/oolim_top_tb.sv */
`default_nettype none
module oolim_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic run = 1'b0;
  logic [15:0] cmd = 16'h01F4;
  logic sel = 1'b0;
  logic [1:0] m1 = 2'h0;
  logic [1:0] m2 = 2'h0;
  logic [7:0] t1 = 8'h64;
  logic [7:0] t2 = 8'h64;
  logic [15:0] st1 = 16'h0064;
  logic [15:0] st2 = 16'h00C8;
  logic [1:0] ocm = 2'h0;
  logic light = 1'b0;
  logic [15:0] load = 16'h04B0;
  logic regen = 1'b0;
  logic [15:0] cur;
  logic [15:0] rated;
  logic regen_q;
  logic [15:0] fo;
  logic steady, lim, racc, ocs, vred;
  logic [15:0] f0;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  logic [1:0] oc_mode [5] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h3};
  logic [15:0] oc_load [5] = '{16'h0708, 16'h0709, 16'h0709, 16'h076C,
                               16'h076C};
  logic [4:0] oc_exp = 5'b00110;
  logic [4:0] vr_exp = 5'b00100;

  oolim_stage i_oolim_stage (.i_mclk(mclk), .i_resetn(resetn),
    .i_load(load), .i_regen(regen), .o_current(cur), .o_rated(rated),
    .o_regen(regen_q));

  oolim_top #(.FW(16), .CYC_PER_UNIT(10)) i_oolim_top (
    .i_mclk(mclk), .i_resetn(resetn), .i_run(run), .i_freq_cmd(cmd),
    .i_fmax(16'h03E8), .i_accel_time(16'h00C8), .i_decel_time(16'h00C8),
    .i_limit_set_select_input(sel), .i_overload_limit1_mode(m1),
    .i_overload_limit1_threshold(t1),
    .i_overload_limit1_slope_time(st1),
    .i_overload_limit2_mode(m2), .i_overload_limit2_threshold(t2),
    .i_overload_limit2_slope_time(st2),
    .i_overcurrent_suppress_mode(ocm), .i_light_duty_rating(light),
    .i_current(cur), .i_rated_current(rated), .i_regen_load(regen_q),
    .o_freq_out(fo), .o_steady(steady), .o_limiting(lim),
    .o_regen_accel(racc), .o_oc_suppress(ocs), .o_volt_reduce(vred));

  always #20 mclk = ~mclk;

  task automatic wrap_up();
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for the ramp to settle, then checks the frequency reached
  task automatic settle(input int lim_cyc, input logic [15:0] f);
    int k;
    k = 0;
    tick(3);
    while (steady !== 1'b1 && k < lim_cyc) begin
      tick(1);
      k++;
    end
    chk("freq_settled", f, fo);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      $display("BAD timeout expected 0 seen 1");
      wrap_up();
    end
  end

  initial begin
    tick(8);
    chk("freq_reset", 16'h0000, fo);
    chk("lim_reset", 16'h0000, {15'h0, lim});
    resetn <= 1'b1;
    tick(3);
    run <= 1'b1;
    tick(200);
    chk("lim_mode0", 16'h0000, {15'h0, lim});
    settle(1500, 16'h01F4);
    m1 <= 2'h1;
    tick(4);
    chk("lim_mode1", 16'h0001, {15'h0, lim});
    f0 = fo;
    tick(100);
    n = int'(f0) - int'(fo);
    chk("slope_drop", 16'h0001, {15'h0, n >= 95 && n <= 100});
    load <= 16'h01F4;
    tick(4);
    chk("lim_release", 16'h0000, {15'h0, lim});
    settle(600, 16'h01F4);
    m1 <= 2'h3;
    regen <= 1'b1;
    tick(4);
    chk("regen_acc", 16'h0001, {15'h0, racc});
    f0 = fo;
    tick(50);
    n = int'(fo) - int'(f0);
    chk("regen_rise", 16'h0001, {15'h0, n >= 45 && n <= 50});
    regen <= 1'b0;
    settle(600, 16'h01F4);
    m1 <= 2'h0;
    m2 <= 2'h1;
    load <= 16'h04B0;
    tick(5);
    chk("set1_sel", 16'h0000, {15'h0, lim});
    sel <= 1'b1;
    tick(4);
    chk("set2_sel", 16'h0001, {15'h0, lim});
    f0 = fo;
    tick(100);
    n = int'(f0) - int'(fo);
    chk("set2_slope", 16'h0001, {15'h0, n >= 45 && n <= 50});
    sel <= 1'b0;
    load <= 16'h01F4;
    settle(600, 16'h01F4);
    m1 <= 2'h1;
    t1 <= 8'hFA;
    load <= 16'h0640;
    tick(5);
    chk("thr_nd", 16'h0000, {15'h0, lim});
    light <= 1'b1;
    tick(4);
    chk("thr_ld", 16'h0001, {15'h0, lim});
    light <= 1'b0;
    t1 <= 8'h64;
    m1 <= 2'h0;
    load <= 16'h01F4;
    settle(600, 16'h01F4);
    for (int i = 0; i < 5; i++) begin
      ocm <= oc_mode[i];
      load <= oc_load[i];
      tick(4);
      chk("oc_suppress", {15'h0, oc_exp[i]}, {15'h0, ocs});
      chk("volt_reduce", {15'h0, vr_exp[i]}, {15'h0, vred});
      load <= 16'h01F4;
      settle(600, 16'h01F4);
    end
    ocm <= 2'h0;
    m1 <= 2'h2;
    cmd <= 16'h0384;
    load <= 16'h04B0;
    tick(300);
    chk("mode2_accel", 16'h0000, {15'h0, lim});
    tick(600);
    chk("mode2_steady", 16'h0001, {15'h0, lim});
    load <= 16'h01F4;
    settle(1500, 16'h0384);
    cmd <= 16'h0064;
    settle(2500, 16'h0064);
    m1 <= 2'h1;
    cmd <= 16'h01F4;
    tick(100);
    load <= 16'h04B0;
    tick(100);
    load <= 16'h01F4;
    n = 200;
    while (steady !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    chk("accel_stretch", 16'h0001, {15'h0, n > 1000});
    chk("freq_final", 16'h01F4, fo);
    wrap_up();
  end
endmodule
`default_nettype wire
